// ### rtl/nsoc_map.vh
// Constants of the negative sequence overcurrent stage: curve codes,
// curve coefficients, setting limits and the millisecond time base.
// Included by every design file of the stage; holds definitions only.
`ifndef NSOC_MAP_VH
`define NSOC_MAP_VH

// Time base: clock rate in kHz and the timer tick in milliseconds.
`define NSOC_CLK_KHZ      16'hC350
`define NSOC_TICK_MS      16'h0001
`define NSOC_MS_SCALE     36'h0_0000_03E8

// Curve select codes.
`define NSOC_SEL_OFF      4'h0
`define NSOC_SEL_DT       4'h1
`define NSOC_SEL_IEC_INV  4'h2
`define NSOC_SEL_IEC_VINV 4'h3
`define NSOC_SEL_IEC_EINV 4'h4
`define NSOC_SEL_IEC_LINV 4'h5
`define NSOC_SEL_ANS_INV  4'h6
`define NSOC_SEL_ANS_MINV 4'h7
`define NSOC_SEL_ANS_VINV 4'h8
`define NSOC_SEL_ANS_EINV 4'h9
`define NSOC_SEL_ANS_LINV 4'hA
`define NSOC_SEL_ANS_LVIN 4'hB
`define NSOC_SEL_ANS_LEIN 4'hC

// Exponent codes: 0.02, 1 and 2.
`define NSOC_ALPHA_002    2'h0
`define NSOC_ALPHA_1      2'h1
`define NSOC_ALPHA_2      2'h2

// Operate constant k, in units of 0.1 ms.
`define NSOC_K_IEC_INV    21'h00_0578
`define NSOC_K_IEC_VINV   21'h02_0F58
`define NSOC_K_IEC_EINV   21'h0C_3500
`define NSOC_K_IEC_LINV   21'h12_4F80
`define NSOC_K_ANS_INV    21'h00_0056
`define NSOC_K_ANS_MINV   21'h00_0203
`define NSOC_K_ANS_VINV   21'h02_FE04
`define NSOC_K_ANS_EINV   21'h04_4D90
`define NSOC_K_ANS_LINV   21'h00_035C
`define NSOC_K_ANS_LVIN   21'h04_5B3C
`define NSOC_K_ANS_LEIN   21'h09_C6BC

// Operate constant c, in units of 0.1 ms.
`define NSOC_C_ZERO       13'h0000
`define NSOC_C_ANS_INV    13'h00B9
`define NSOC_C_ANS_MINV   13'h0474
`define NSOC_C_ANS_VINV   13'h132E
`define NSOC_C_ANS_EINV   13'h04C1
`define NSOC_C_ANS_LINV   13'h073A
`define NSOC_C_ANS_LVIN   13'h1BD0
`define NSOC_C_ANS_LEIN   13'h09C4

// Reset constant kr, in units of 0.1 ms, exponent 2.
`define NSOC_KR_NONE      19'h0_0000
`define NSOC_KR_ANS_INV   19'h0_11F8
`define NSOC_KR_ANS_MINV  19'h0_BD74
`define NSOC_KR_ANS_VINV  19'h3_4BC0
`define NSOC_KR_ANS_EINV  19'h4_70B8
`define NSOC_KR_ANS_LINV  19'h0_B3B0
`define NSOC_KR_ANS_LVIN  19'h2_0DC8
`define NSOC_KR_ANS_LEIN  19'h4_93E0

// Exponent 0.02 is taken as 0.02*ln(2)*log2(ratio), scaled by 2^24.
`define NSOC_LN_COEF      10'h38D
`define NSOC_LN_DEN       40'h00_0100_0000

// Setting limits: percent, milliseconds and hundredths.
`define NSOC_START_MIN    10'h00A
`define NSOC_START_MAX    10'h3E8
`define NSOC_DELAY_MIN    16'h0028
`define NSOC_RESET_MIN    16'h003C
`define NSOC_DELAY_MAX    16'hEA60
`define NSOC_TMS_MIN      11'h005
`define NSOC_TMS_MAX      11'h5DC

`endif

// ### rtl/nsoc_curve_calc.v
// Curve coefficient table and the ratio terms of the dependent curves.
// Purely combinational; the stage samples its results on the timer tick.
`timescale 1ns/10ps
`default_nettype none
`include "nsoc_map.vh"

module nsoc_curve_calc (
  input  wire [3:0]  curve_sel,
  input  wire [19:0] g_meas,
  input  wire [19:0] g_start,
  output reg  [20:0] k_op,
  output reg  [12:0] c_op,
  output reg  [18:0] k_rst,
  output reg         ansi_curve,
  output reg  [39:0] op_num,
  output reg  [39:0] op_den,
  output wire [39:0] rst_num,
  output wire [39:0] rst_den
);

  reg  [1:0]  alpha;
  wire [39:0] g_sq;
  wire [39:0] gs_sq;
  wire [12:0] log_g;
  wire [12:0] log_gs;
  wire [12:0] log_diff;
  wire [22:0] ln_term;

  // Leading-one position plus a linear mantissa; the error largely
  // cancels because both operands carry it.
  function [12:0] log2_approx;
    input [19:0] x;
    integer i;
    reg [4:0]  p;
    reg [19:0] m;
    begin
      p = 5'h00;
      for (i = 0; i < 20; i = i + 1) begin
        if (x[i])
          p = i[4:0];
      end
      m = x << (5'h13 - p);
      log2_approx = {p, m[18:11]};
    end
  endfunction

  always @* begin
    k_op       = `NSOC_K_IEC_INV;
    c_op       = `NSOC_C_ZERO;
    k_rst      = `NSOC_KR_NONE;
    alpha      = `NSOC_ALPHA_002;
    ansi_curve = 1'b0;
    case (curve_sel)
      `NSOC_SEL_IEC_VINV: begin
        k_op  = `NSOC_K_IEC_VINV;
        alpha = `NSOC_ALPHA_1;
      end
      `NSOC_SEL_IEC_EINV: begin
        k_op  = `NSOC_K_IEC_EINV;
        alpha = `NSOC_ALPHA_2;
      end
      `NSOC_SEL_IEC_LINV: begin
        k_op  = `NSOC_K_IEC_LINV;
        alpha = `NSOC_ALPHA_1;
      end
      `NSOC_SEL_ANS_INV: begin
        k_op       = `NSOC_K_ANS_INV;
        c_op       = `NSOC_C_ANS_INV;
        k_rst      = `NSOC_KR_ANS_INV;
        ansi_curve = 1'b1;
      end
      `NSOC_SEL_ANS_MINV: begin
        k_op       = `NSOC_K_ANS_MINV;
        c_op       = `NSOC_C_ANS_MINV;
        k_rst      = `NSOC_KR_ANS_MINV;
        ansi_curve = 1'b1;
      end
      `NSOC_SEL_ANS_VINV: begin
        k_op       = `NSOC_K_ANS_VINV;
        c_op       = `NSOC_C_ANS_VINV;
        k_rst      = `NSOC_KR_ANS_VINV;
        alpha      = `NSOC_ALPHA_2;
        ansi_curve = 1'b1;
      end
      `NSOC_SEL_ANS_EINV: begin
        k_op       = `NSOC_K_ANS_EINV;
        c_op       = `NSOC_C_ANS_EINV;
        k_rst      = `NSOC_KR_ANS_EINV;
        alpha      = `NSOC_ALPHA_2;
        ansi_curve = 1'b1;
      end
      `NSOC_SEL_ANS_LINV: begin
        k_op       = `NSOC_K_ANS_LINV;
        c_op       = `NSOC_C_ANS_LINV;
        k_rst      = `NSOC_KR_ANS_LINV;
        ansi_curve = 1'b1;
      end
      `NSOC_SEL_ANS_LVIN: begin
        k_op       = `NSOC_K_ANS_LVIN;
        c_op       = `NSOC_C_ANS_LVIN;
        k_rst      = `NSOC_KR_ANS_LVIN;
        alpha      = `NSOC_ALPHA_2;
        ansi_curve = 1'b1;
      end
      `NSOC_SEL_ANS_LEIN: begin
        k_op       = `NSOC_K_ANS_LEIN;
        c_op       = `NSOC_C_ANS_LEIN;
        k_rst      = `NSOC_KR_ANS_LEIN;
        alpha      = `NSOC_ALPHA_2;
        ansi_curve = 1'b1;
      end
      default: begin
        k_op = `NSOC_K_IEC_INV;
      end
    endcase
  end

  assign g_sq     = g_meas * g_meas;
  assign gs_sq    = g_start * g_start;
  assign log_g    = log2_approx(g_meas);
  assign log_gs   = log2_approx(g_start);
  assign log_diff = (log_g > log_gs) ? (log_g - log_gs) : 13'h0000;
  // The product gets its own full-width net; inside a concatenation it
  // would be cut to the width of its widest operand.
  assign ln_term  = log_diff * `NSOC_LN_COEF;

  // The curve term (G/Gs)^alpha - 1 as a fraction op_num / op_den.
  always @* begin
    case (alpha)
      `NSOC_ALPHA_1: begin
        op_num = {20'h0_0000, g_meas - g_start};
        op_den = {20'h0_0000, g_start};
      end
      `NSOC_ALPHA_2: begin
        op_num = g_sq - gs_sq;
        op_den = gs_sq;
      end
      default: begin
        op_num = {17'h0_0000, ln_term};
        op_den = `NSOC_LN_DEN;
      end
    endcase
  end

  // Reset term 1 - (G/Gs)^2; only used while G lies below Gs.
  assign rst_num = (g_meas < g_start) ? (gs_sq - g_sq) : 40'h00_0000_0000;
  assign rst_den = gs_sq;

endmodule // nsoc_curve_calc
`default_nettype wire

// ### rtl/nsoc_stage.v
// Negative sequence overcurrent stage: start detection, operate timing
// on definite or dependent curves, and fixed or dependent reset timing.
// Assumes the magnitude and all settings are synchronous to clk_sys and
// that the magnitude uses the start setting's unit with 4 fraction bits.
`timescale 1ns/10ps
`default_nettype none
`include "nsoc_map.vh"

module nsoc_stage #(
  parameter [15:0] TICK_CYCLES = `NSOC_CLK_KHZ * `NSOC_TICK_MS
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [19:0] negseq_current_magnitude,
  input  wire [3:0]  curve_select_setting,
  input  wire [9:0]  start_current_setting,
  input  wire [10:0] time_multiplier_setting,
  input  wire [15:0] minimum_delay_setting,
  input  wire [15:0] definite_delay_setting,
  input  wire [15:0] reset_delay_setting,
  input  wire        block_input,
  output reg         start_output,
  output reg         trip_output
);

  localparam [25:0] MS_LIMIT = 26'h3FF_FFFF;

  reg  [15:0] tick_cnt;
  reg         tick;
  reg  [25:0] op_ms;
  reg  [25:0] rst_ms;

  wire [9:0]  start_eff;
  wire [10:0] tms_eff;
  wire [15:0] min_eff;
  wire [15:0] def_eff;
  wire [15:0] rdel_eff;
  wire [19:0] g_start;
  wire [19:0] g_limit;
  wire [19:0] g_curve;
  wire        enabled;
  wire        over;
  wire        dt_mode;
  wire        dep_mode;

  wire [20:0] k_op;
  wire [12:0] c_op;
  wire [18:0] k_rst;
  wire        ansi_curve;
  wire [39:0] op_num;
  wire [39:0] op_den;
  wire [39:0] rst_num;
  wire [39:0] rst_den;

  wire [35:0] op_scaled;
  wire [35:0] rst_scaled;
  wire [35:0] tms_c;
  wire [31:0] tms_k;
  wire [29:0] tms_kr;
  wire [35:0] op_margin;
  wire [79:0] op_lhs;
  wire [79:0] op_rhs;
  wire [79:0] rst_lhs;
  wire [79:0] rst_rhs;
  wire        op_curve_due;
  wire        op_due;
  wire        rst_due;

  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < lo)
        clamp16 = lo;
      else if (v > hi)
        clamp16 = hi;
      else
        clamp16 = v;
    end
  endfunction

  // Settings are clamped rather than rejected so the stage always has a
  // usable value, even while software is midway through an update.
  assign start_eff = (start_current_setting < `NSOC_START_MIN) ?
                     `NSOC_START_MIN :
                     (start_current_setting > `NSOC_START_MAX) ?
                     `NSOC_START_MAX : start_current_setting;
  assign tms_eff   = (time_multiplier_setting < `NSOC_TMS_MIN) ?
                     `NSOC_TMS_MIN :
                     (time_multiplier_setting > `NSOC_TMS_MAX) ?
                     `NSOC_TMS_MAX : time_multiplier_setting;
  assign min_eff   = clamp16(minimum_delay_setting, `NSOC_DELAY_MIN,
                             `NSOC_DELAY_MAX);
  assign def_eff   = clamp16(definite_delay_setting, `NSOC_DELAY_MIN,
                             `NSOC_DELAY_MAX);
  assign rdel_eff  = clamp16(reset_delay_setting, `NSOC_RESET_MIN,
                             `NSOC_DELAY_MAX);

  assign g_start  = {6'h00, start_eff, 4'h0};
  assign g_limit  = {g_start[17:0], 2'b00} + {g_start[15:0], 4'h0};
  assign over     = negseq_current_magnitude > g_start;
  // Beyond twenty times start the curve sees the limit itself.
  assign g_curve  = (negseq_current_magnitude > g_limit) ?
                    g_limit : negseq_current_magnitude;

  assign enabled  = (curve_select_setting != `NSOC_SEL_OFF) &&
                    (curve_select_setting <= `NSOC_SEL_ANS_LEIN) &&
                    !block_input;
  assign dt_mode  = curve_select_setting == `NSOC_SEL_DT;
  assign dep_mode = enabled && !dt_mode;

  nsoc_curve_calc u_curve (
    .curve_sel  (curve_select_setting),
    .g_meas     (g_curve),
    .g_start    (g_start),
    .k_op       (k_op),
    .c_op       (c_op),
    .k_rst      (k_rst),
    .ansi_curve (ansi_curve),
    .op_num     (op_num),
    .op_den     (op_den),
    .rst_num    (rst_num),
    .rst_den    (rst_den)
  );

  // All times meet in units of 1 us: ms times 1000, hundredths of TMS
  // times tenths of a ms. Comparing cross products avoids any divider.
  assign op_scaled  = op_ms * `NSOC_MS_SCALE;
  assign rst_scaled = rst_ms * `NSOC_MS_SCALE;
  assign tms_c      = tms_eff * c_op;
  assign tms_k      = tms_eff * k_op;
  assign tms_kr     = tms_eff * k_rst;
  assign op_margin  = (op_scaled > tms_c) ? (op_scaled - tms_c) :
                      36'h0_0000_0000;
  assign op_lhs     = op_margin * op_num;
  assign op_rhs     = tms_k * op_den;
  assign rst_lhs    = rst_scaled * rst_num;
  assign rst_rhs    = tms_kr * rst_den;

  // A zero curve term means a ratio too close to one to resolve; the
  // stage then waits, which stays inside the 1.1 guarantee.
  assign op_curve_due = (op_num != 40'h00_0000_0000) &&
                        (op_margin != 36'h0_0000_0000) &&
                        (op_lhs >= op_rhs);
  assign op_due = dt_mode ? ({10'h000, def_eff} <= op_ms) :
                  (op_curve_due &&
                   ({10'h000, min_eff} <= op_ms));
  assign rst_due = ansi_curve ?
                   ((rst_num != 40'h00_0000_0000) &&
                    (rst_lhs >= rst_rhs)) :
                   ({10'h000, rdel_eff} <= rst_ms);

  // Millisecond tick; the timers advance only on it.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 16'h0001) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_output <= 1'b0;
    end else begin
      start_output <= enabled && over;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_ms       <= 26'h000_0000;
      rst_ms      <= 26'h000_0000;
      trip_output <= 1'b0;
    end else if (!enabled) begin
      op_ms       <= 26'h000_0000;
      rst_ms      <= 26'h000_0000;
      trip_output <= 1'b0;
    end else if (tick) begin
      if (over) begin
        rst_ms <= 26'h000_0000;
        if (op_ms != MS_LIMIT)
          op_ms <= op_ms + 26'h000_0001;
        if (op_due)
          trip_output <= 1'b1;
      end else if (dt_mode) begin
        // Definite time drops on the next tick when the quantity falls back.
        op_ms       <= 26'h000_0000;
        trip_output <= 1'b0;
      end else if (dep_mode &&
                   ((op_ms != 26'h000_0000) || trip_output)) begin
        if (rst_due) begin
          op_ms       <= 26'h000_0000;
          rst_ms      <= 26'h000_0000;
          trip_output <= 1'b0;
        end else if (rst_ms != MS_LIMIT) begin
          rst_ms <= rst_ms + 26'h000_0001;
        end
      end
    end
  end

endmodule // nsoc_stage
`default_nettype wire

// ### testbench/nsoc_stage_monitor.sv
// Checker of the negative sequence overcurrent stage, on its ports only.
// Assumes one clk_sys domain and the same tick length as the stage.
`timescale 1ns/10ps
`default_nettype none
`include "nsoc_map.vh"

module nsoc_stage_monitor #(
  parameter [15:0] TICK_CYCLES = 16'h0032
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [19:0] negseq_current_magnitude,
  input wire logic [3:0]  curve_select_setting,
  input wire logic [9:0]  start_current_setting,
  input wire logic [10:0] time_multiplier_setting,
  input wire logic [15:0] minimum_delay_setting,
  input wire logic [15:0] definite_delay_setting,
  input wire logic [15:0] reset_delay_setting,
  input wire logic        block_input,
  input wire logic        start_output,
  input wire logic        trip_output
);
  logic [9:0]  gs;
  logic [15:0] dd;
  logic        en;
  logic        over;
  logic        iec;
  logic        dt;
  logic [31:0] n_hi;
  logic [31:0] n_lo;

  assign gs = (start_current_setting < `NSOC_START_MIN) ? `NSOC_START_MIN :
    (start_current_setting > `NSOC_START_MAX) ? `NSOC_START_MAX :
    start_current_setting;
  assign dd = (definite_delay_setting < `NSOC_DELAY_MIN) ? `NSOC_DELAY_MIN :
    (definite_delay_setting > `NSOC_DELAY_MAX) ? `NSOC_DELAY_MAX :
    definite_delay_setting;
  assign dt = curve_select_setting == `NSOC_SEL_DT;
  assign en = !block_input && curve_select_setting != `NSOC_SEL_OFF &&
    curve_select_setting <= `NSOC_SEL_ANS_LEIN;
  assign over = en && negseq_current_magnitude > {6'h00, gs, 4'h0};
  assign iec = curve_select_setting >= `NSOC_SEL_IEC_INV &&
    curve_select_setting <= `NSOC_SEL_IEC_LINV;

  // The over count only restarts where the stage surely loses its
  // accumulated time, so it never claims less time than really ran.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      n_hi <= 32'h0000_0000;
      n_lo <= 32'h0000_0000;
    end else begin
      n_hi <= (!en || (dt && !start_output)) ? 32'h0000_0000 :
        n_hi + {31'h0000_0000, start_output};
      n_lo <= start_output ? 32'h0000_0000 : n_lo + 32'h0000_0001;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_start_set;
    over |=> start_output;
  endproperty
  a_start_set: assert property (p_start_set)
    else $error("start missing while above the start value");
  property p_start_only;
    start_output |-> $past(over);
  endproperty
  a_start_only: assert property (p_start_only)
    else $error("start without a cause");
  property p_block;
    block_input |=> !start_output && !trip_output;
  endproperty
  a_block: assert property (p_block)
    else $error("output active under block");
  property p_off;
    curve_select_setting == `NSOC_SEL_OFF |=> !start_output && !trip_output;
  endproperty
  a_off: assert property (p_off)
    else $error("output active while off");
  property p_trip_hold;
    trip_output && over |=> trip_output;
  endproperty
  a_trip_hold: assert property (p_trip_hold)
    else $error("trip cleared while still above");
  property p_min_time;
    $rose(trip_output) |-> n_hi >= 39 * TICK_CYCLES;
  endproperty
  a_min_time: assert property (p_min_time)
    else $error("trip before the shortest delay");
  property p_def_trip;
    dt && en && n_hi >= (dd + 2) * TICK_CYCLES |-> trip_output;
  endproperty
  a_def_trip: assert property (p_def_trip)
    else $error("definite trip late");
  property p_iec_reset;
    $fell(trip_output) && $past(en) && $past(iec) |-> n_lo >= 59 * TICK_CYCLES;
  endproperty
  a_iec_reset: assert property (p_iec_reset)
    else $error("fixed reset too early");
endmodule // nsoc_stage_monitor

bind nsoc_stage nsoc_stage_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
  .clk_sys(clk_sys), .rst(rst),
  .negseq_current_magnitude(negseq_current_magnitude),
  .curve_select_setting(curve_select_setting),
  .start_current_setting(start_current_setting),
  .time_multiplier_setting(time_multiplier_setting),
  .minimum_delay_setting(minimum_delay_setting),
  .definite_delay_setting(definite_delay_setting),
  .reset_delay_setting(reset_delay_setting),
  .block_input(block_input), .start_output(start_output),
  .trip_output(trip_output)
);
`default_nettype wire

// ### testbench/nsoc_upstream_model.sv
// Upstream phasor stage model: reports the negative sequence magnitude.
// Assumes one clk_sys domain; the bench chooses the level to report.
`timescale 1ns/10ps
`default_nettype none

module nsoc_upstream_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [19:0] level,
  output var  logic [19:0] magnitude
);
  // One register stands in for the filter latency of the real source.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      magnitude <= 20'h0_0000;
    end else begin
      magnitude <= level;
    end
  end
endmodule // nsoc_upstream_model
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench of the negative sequence overcurrent stage.
// Assumes a short tick of 50 cycles, so one timer millisecond is 1 us.
`timescale 1ns/10ps
`default_nettype none
`include "nsoc_map.vh"

module tb;
  localparam int TK = 50;
  logic        clk_sys;
  logic        rst;
  logic [19:0] level;
  logic [19:0] mag;
  logic [3:0]  sel;
  logic [9:0]  gs;
  logic [10:0] tms;
  logic [15:0] mind;
  logic [15:0] defd;
  logic [15:0] rstd;
  logic        blk;
  logic        st;
  logic        tr;
  int          failures;
  int          n_tests;
  real kk [11] = '{0.14, 13.5, 80.0, 120.0, 0.0086, 0.0515, 19.61, 28.2,
                   0.086, 28.55, 64.07};
  real cc [11] = '{0.0, 0.0, 0.0, 0.0, 0.0185, 0.114, 0.491, 0.1217,
                   0.185, 0.712, 0.25};
  real aa [11] = '{0.02, 1.0, 2.0, 1.0, 0.02, 0.02, 2.0, 2.0, 0.02, 2.0, 2.0};

  nsoc_upstream_model u_src (.clk_sys(clk_sys), .rst(rst), .level(level),
    .magnitude(mag));
  nsoc_stage #(.TICK_CYCLES(16'h0032)) uut (.clk_sys(clk_sys), .rst(rst),
    .negseq_current_magnitude(mag), .curve_select_setting(sel),
    .start_current_setting(gs), .time_multiplier_setting(tms),
    .minimum_delay_setting(mind), .definite_delay_setting(defd),
    .reset_delay_setting(rstd), .block_input(blk),
    .start_output(st), .trip_output(tr));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic near(input real got, input real e, input real tol,
                      input string msg);
    check(got >= e - tol && got <= e + tol, 1'b1, msg);
  endtask

  // Counts cycles until trip shows the wanted level, in timer ms.
  task automatic wait_trip(input logic v, output real ms);
    int n;
    n = 0;
    while (tr !== v) begin
      @(negedge clk_sys);
      n++;
      if (n > 400 * TK) begin
        check(tr, v, "trip wait timed out");
        summarize();
      end
    end
    ms = real'(n) / TK;
  endtask

  task automatic t_threshold();
    @(negedge clk_sys);
    check(st, 1'b0, "start after reset");
    check(tr, 1'b0, "trip after reset");
    @(posedge clk_sys);
    sel <= `NSOC_SEL_DT;
    level <= 20'h0_0320;
    repeat (3) @(negedge clk_sys);
    check(st, 1'b0, "start at equal level");
    @(posedge clk_sys);
    level <= 20'h0_0321;
    repeat (3) @(negedge clk_sys);
    check(st, 1'b1, "start just above");
    @(posedge clk_sys);
    blk <= 1'b1;
    repeat (2) @(negedge clk_sys);
    check(st, 1'b0, "start under block");
    @(posedge clk_sys);
    blk <= 1'b0;
    level <= 20'h0_0000;
    @(posedge clk_sys);
    gs <= 10'h000;
    level <= 20'h0_00A1;
    repeat (3) @(negedge clk_sys);
    check(st, 1'b1, "start above clamped minimum");
    @(posedge clk_sys);
    level <= 20'h0_00A0;
    repeat (3) @(negedge clk_sys);
    check(st, 1'b0, "start at clamped minimum");
    @(posedge clk_sys);
    gs <= 10'h032;
    level <= 20'h0_0000;
  endtask

  task automatic t_definite();
    real ms;
    @(posedge clk_sys);
    level <= 20'h0_0640;
    wait_trip(1'b1, ms);
    near(ms, 40.5, 1.0, "definite delay");
    repeat (3 * TK) @(negedge clk_sys);
    check(tr, 1'b1, "trip held while above");
    @(posedge clk_sys);
    blk <= 1'b1;
    repeat (2) @(negedge clk_sys);
    check(tr, 1'b0, "trip under block");
    @(posedge clk_sys);
    blk <= 1'b0;
    wait_trip(1'b1, ms);
    near(ms, 40.5, 1.0, "definite delay after block");
    @(posedge clk_sys);
    level <= 20'h0_0000;
    wait_trip(1'b0, ms);
    near(ms, 0.5, 1.0, "definite release");
  endtask

  task automatic trip_at(input logic [3:0] s, input logic [19:0] g,
                         input real e);
    real ms;
    @(posedge clk_sys);
    sel <= s;
    level <= g;
    wait_trip(1'b1, ms);
    near(ms, e, e * 0.08 + 2.0, "operate time");
    @(posedge clk_sys);
    sel <= `NSOC_SEL_OFF;
    repeat (2) @(negedge clk_sys);
    check(tr, 1'b0, "trip while off");
    check(st, 1'b0, "start while off");
  endtask

  task automatic reset_at(input logic [3:0] s, input real e);
    real ms;
    @(posedge clk_sys);
    sel <= s;
    level <= 20'h0_7D00;
    wait_trip(1'b1, ms);
    @(posedge clk_sys);
    level <= 20'h0_0190;
    wait_trip(1'b0, ms);
    near(ms, e, e * 0.05 + 1.5, "reset time");
  endtask

  task automatic t_curves();
    real e;
    for (int i = 0; i < 11; i++) begin
      e = 1000.0 * 0.05 * (kk[i] / ((20.0 ** aa[i]) - 1.0) + cc[i]);
      if (e < 40.0) e = 40.0;
      trip_at(4'(i + 2), 20'h0_7D00, e);
    end
    trip_at(`NSOC_SEL_IEC_VINV, 20'h0_1F40, 75.0);
  endtask

  initial begin
    failures = 0;
    n_tests = 0;
    rst = 1'b1;
    level = 20'h0_0000;
    sel = `NSOC_SEL_OFF;
    gs = 10'h032;
    tms = 11'h005;
    mind = 16'h0028;
    defd = 16'h0028;
    rstd = 16'h0000;
    blk = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_threshold();
    t_definite();
    t_curves();
    reset_at(`NSOC_SEL_IEC_VINV, 60.5);
    reset_at(`NSOC_SEL_ANS_INV, 30.7);
    summarize();
  end
endmodule // tb
`default_nettype wire
